// [rtcapt_pkg.sv]
//------------------------------------------------------------
// Function
//------------------------------------------------------------
package rtcapt_pkg;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_DIV = 12'h004;
  localparam logic [11:0] OFF_PWC = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00C;
  localparam logic [11:0] OFF_TSTL = 12'h010;
  localparam logic [11:0] OFF_TSTH = 12'h014;
  localparam logic [11:0] OFF_TSDL = 12'h018;
  localparam logic [11:0] OFF_TSDH = 12'h01C;
  localparam logic [11:0] OFF_ALT = 12'h020;
  localparam logic [11:0] OFF_ALD = 12'h024;
  // Register field positions, codes, reset values and masks
  localparam int CTL_CAL_EN = 0;
  localparam int CTL_STAMP_EN = 1;
  localparam int CTL_ALM_EN = 2;
  localparam int CTL_ENDLESS_REPEAT = 3;
  localparam int CTL_PWC_EN = 4;
  localparam int CTL_PWC_POL = 5;
  localparam int CTL_OE = 6;
  localparam int CTL_MASK_LSB = 8;
  localparam int CTL_RPT_LSB = 16;
  localparam int CTL_SRC_LSB = 24;
  localparam int CTL_PS_LSB = 28;
  localparam int STAT_EVT = 3;
  localparam logic [2:0] SRC_PWC = 3'h3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [20:0] PRESC_RST = 21'h0F_FFE0;
  localparam logic [15:0] PWC_RST = 16'h0000;
  localparam logic [15:0] DATEL_MASK = 16'h3F07;
  localparam logic [15:0] DATEH_MASK = 16'hFF1F;
  localparam logic [15:0] TIMEL_MASK = 16'h7F00;
  localparam logic [15:0] TIMEH_MASK = 16'h3F7F;
  localparam logic [7:0] WIN_OFF = 8'h00;
  localparam logic [7:0] WIN_HOLD = 8'hFF;

  // Calendar digits for capture and compare
  typedef struct packed {
    logic [15:0] time_h;
    logic [15:0] time_l;
    logic [15:0] date_h;
    logic [15:0] date_l;
  } rtcapt_cal_t;

  typedef enum logic [1:0] {
    PW_IDLE = 2'b00,
    PW_STAB = 2'b01,
    PW_SAMP = 2'b10
  } rtcapt_pw_t;
endpackage

// [rtcapt_top.sv]
`timescale 1ns/1ps
module rtcapt_top (
  input wire logic mclk_i,                    // Clock, 10 MHz
  input wire logic rst_n_i,                   // Async reset, low
  input wire logic por_n_i,                   // Power-on reset, low
  input wire logic psel_i,                    // APB select
  input wire logic penable_i,                 // APB enable
  input wire logic pwrite_i,                  // APB write
  input wire logic [11:0] paddr_i,            // APB address
  input wire logic [31:0] pwdata_i,           // APB write data
  output logic [31:0] prdata_o,               // APB read data
  output logic pready_o,                      // APB ready
  output logic pslverr_o,                     // APB error
  input wire logic half_sec_i,                // Half-second strobe
  input wire rtcapt_pkg::rtcapt_cal_t cal_i,  // Live calendar
  input wire logic tamper_input_n_i,          // Tamper input, low
  output logic sec_tick_o,                    // One-second tick
  output logic alarm_irq_o,                   // Alarm pulse
  output logic stamp_irq_o,                   // Stamp pulse
  output logic pin_o,                         // Clock pin level
  output logic pin_oe_o,                      // Clock pin enable
  output logic power_control_o,               // Power control
  output logic sample_gate_o                  // Sample gate
);
  //----------------------------------------
  // Registers
  //----------------------------------------
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [20:0] presc_ff, nxt_presc;
  logic [15:0] pwc_ff, nxt_pwc;
  logic [31:0] alt_ff, nxt_alt, ald_ff, nxt_ald;
  logic evt_ff, nxt_evt;
  logic [20:0] pcnt_ff, nxt_pcnt;
  logic tamp_ff, nxt_tamp;
  logic [7:0] pdiv_ff, nxt_pdiv;
  logic [7:0] wcnt_ff, nxt_wcnt;
  rtcapt_pkg::rtcapt_pw_t pw_ff, nxt_pw;
  rtcapt_pkg::rtcapt_cal_t ts_ff, nxt_ts;
  logic wr, rd, hit, cap;
  logic alm_match, alm_fire, pclk_en, stab_hold, pw_on;

  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & ~pwrite_i;
  assign pready_o = 1'b1;

  // Address decode
  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      rtcapt_pkg::OFF_CTRL, rtcapt_pkg::OFF_DIV, rtcapt_pkg::OFF_PWC,
      rtcapt_pkg::OFF_STAT, rtcapt_pkg::OFF_TSTL, rtcapt_pkg::OFF_TSTH,
      rtcapt_pkg::OFF_TSDL, rtcapt_pkg::OFF_TSDH, rtcapt_pkg::OFF_ALT,
      rtcapt_pkg::OFF_ALD: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i & penable_i & ~hit;

  // Read mux
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (rd) begin
      case (paddr_i)
        rtcapt_pkg::OFF_CTRL: prdata_o = ctrl_ff;
        rtcapt_pkg::OFF_DIV: prdata_o = {11'h000, presc_ff};
        rtcapt_pkg::OFF_PWC: prdata_o = {16'h0000, pwc_ff};
        rtcapt_pkg::OFF_STAT: prdata_o = {28'h0000000, evt_ff, 3'h0};
        rtcapt_pkg::OFF_TSTL: prdata_o = {16'h0000, ts_ff.time_l};
        rtcapt_pkg::OFF_TSTH: prdata_o = {16'h0000, ts_ff.time_h};
        rtcapt_pkg::OFF_TSDL: prdata_o = {16'h0000, ts_ff.date_l};
        rtcapt_pkg::OFF_TSDH: prdata_o = {16'h0000, ts_ff.date_h};
        rtcapt_pkg::OFF_ALT: prdata_o = alt_ff;
        rtcapt_pkg::OFF_ALD: prdata_o = ald_ff;
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end

  //----------------------------------------
  // Prescaler tick
  //----------------------------------------
  // Up count of joined divider; larger value, slower tick
  always_comb begin
    nxt_presc = presc_ff;
    if (wr && paddr_i == rtcapt_pkg::OFF_DIV) nxt_presc = pwdata_i[20:0];
    nxt_pcnt = pcnt_ff;
    sec_tick_o = 1'b0;
    if (ctrl_ff[rtcapt_pkg::CTL_CAL_EN]) begin
      if (pcnt_ff >= presc_ff) begin
        nxt_pcnt = 21'h00_0000;
        sec_tick_o = 1'b1;
      end else begin
        nxt_pcnt = pcnt_ff + 21'h00_0001;
      end
    end
  end

  //----------------------------------------
  // Alarm
  //----------------------------------------
  // Compare digits chosen by the interval mask
  always_comb begin
    logic [3:0] m;
    m = ctrl_ff[rtcapt_pkg::CTL_MASK_LSB +: 4];
    alm_match = 1'b1;
    if (m >= 4'h2 && alt_ff[11:8] != cal_i.time_l[11:8]) alm_match = 1'b0;
    if (m >= 4'h3 && alt_ff[14:12] != cal_i.time_l[14:12]) alm_match = 1'b0;
    if (m >= 4'h4 && alt_ff[19:16] != cal_i.time_h[3:0]) alm_match = 1'b0;
    if (m >= 4'h5 && alt_ff[22:20] != cal_i.time_h[6:4]) alm_match = 1'b0;
    if (m >= 4'h6 && alt_ff[29:24] != cal_i.time_h[13:8]) alm_match = 1'b0;
    if (m == 4'h7 && ald_ff[2:0] != cal_i.date_l[2:0]) alm_match = 1'b0;
    if (m >= 4'h8 && m <= 4'h9 && ald_ff[13:8] != cal_i.date_l[13:8]) alm_match = 1'b0;
    if (m == 4'h9 && ald_ff[20:16] != cal_i.date_h[4:0]) alm_match = 1'b0;
    if (m > 4'h9) alm_match = 1'b0;
  end
  // Mask 0 fires every half second, masks 1 to 9 on second boundary, 10 to 15 never
  assign alm_fire = ctrl_ff[rtcapt_pkg::CTL_ALM_EN] & alm_match &
    (ctrl_ff[rtcapt_pkg::CTL_MASK_LSB +: 4] == 4'h0 ? half_sec_i : sec_tick_o);
  assign alarm_irq_o = alm_fire;

  // Control writes and repeat counting
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pwc = pwc_ff;
    nxt_alt = alt_ff;
    nxt_ald = ald_ff;
    if (wr && paddr_i == rtcapt_pkg::OFF_CTRL) nxt_ctrl = pwdata_i;
    if (wr && paddr_i == rtcapt_pkg::OFF_PWC) nxt_pwc = pwdata_i[15:0];
    if (wr && paddr_i == rtcapt_pkg::OFF_ALT) nxt_alt = pwdata_i;
    if (wr && paddr_i == rtcapt_pkg::OFF_ALD) nxt_ald = pwdata_i;
    if (alm_fire) begin
      if (ctrl_ff[rtcapt_pkg::CTL_RPT_LSB +: 8] != 8'h00) begin
        nxt_ctrl[rtcapt_pkg::CTL_RPT_LSB +: 8] = ctrl_ff[rtcapt_pkg::CTL_RPT_LSB +: 8] - 8'h01;
      end else if (ctrl_ff[rtcapt_pkg::CTL_ENDLESS_REPEAT]) begin
        nxt_ctrl[rtcapt_pkg::CTL_RPT_LSB +: 8] = 8'hFF;
      end else begin
        nxt_ctrl[rtcapt_pkg::CTL_ALM_EN] = 1'b0;
      end
    end
  end

  //----------------------------------------
  // Power control
  //----------------------------------------
  // Power clock enable from prescaler
  always_comb begin
    nxt_pdiv = pdiv_ff + 8'h01;
    // Restart divider at cycle start so windows span whole power clocks
    if (pw_ff == rtcapt_pkg::PW_IDLE && alm_fire && ctrl_ff[rtcapt_pkg::CTL_PWC_EN])
      nxt_pdiv = 8'h00;
    case (ctrl_ff[rtcapt_pkg::CTL_PS_LSB +: 2])
      2'b00: pclk_en = 1'b1;
      2'b01: pclk_en = pdiv_ff[3:0] == 4'hF;
      2'b10: pclk_en = pdiv_ff[5:0] == 6'h3F;
      default: pclk_en = pdiv_ff == 8'hFF;
    endcase
  end

  // Cycle starts on an alarm while idle; windows count power clocks
  always_comb begin
    nxt_pw = pw_ff;
    nxt_wcnt = wcnt_ff;
    case (pw_ff)
      rtcapt_pkg::PW_IDLE: begin
        if (alm_fire && ctrl_ff[rtcapt_pkg::CTL_PWC_EN]) begin
          nxt_wcnt = 8'h00;
          nxt_pw = (pwc_ff[7:0] == rtcapt_pkg::WIN_OFF) ? rtcapt_pkg::PW_SAMP
            : rtcapt_pkg::PW_STAB;
        end
      end
      rtcapt_pkg::PW_STAB: begin
        if (pclk_en) nxt_wcnt = wcnt_ff + 8'h01;
        if (pclk_en && wcnt_ff + 8'h01 >= pwc_ff[7:0]) begin
          nxt_wcnt = 8'h00;
          nxt_pw = rtcapt_pkg::PW_SAMP;
        end
      end
      rtcapt_pkg::PW_SAMP: begin
        if (pclk_en) nxt_wcnt = wcnt_ff + 8'h01;
        if (pwc_ff[15:8] == rtcapt_pkg::WIN_OFF ||
            (pclk_en && wcnt_ff + 8'h01 >= pwc_ff[15:8])) begin
          nxt_pw = rtcapt_pkg::PW_IDLE;
        end
      end
      default: nxt_pw = rtcapt_pkg::PW_IDLE;
    endcase
    if (!ctrl_ff[rtcapt_pkg::CTL_PWC_EN]) nxt_pw = rtcapt_pkg::PW_IDLE;
  end
  assign stab_hold = pwc_ff[7:0] == rtcapt_pkg::WIN_HOLD;
  assign pw_on = (pw_ff != rtcapt_pkg::PW_IDLE) | stab_hold;
  assign power_control_o = pw_on ^ ~ctrl_ff[rtcapt_pkg::CTL_PWC_POL];
  assign sample_gate_o = (pw_ff == rtcapt_pkg::PW_SAMP);
  assign pin_oe_o = ctrl_ff[rtcapt_pkg::CTL_OE];
  assign pin_o = (ctrl_ff[rtcapt_pkg::CTL_SRC_LSB +: 3] == rtcapt_pkg::SRC_PWC)
    ? power_control_o : alarm_irq_o;

  //----------------------------------------
  // Timestamp
  //----------------------------------------
  // Capture on tamper fall or software request, blocked by flag
  always_comb begin
    logic sw_req;
    sw_req = wr && paddr_i == rtcapt_pkg::OFF_STAT && pwdata_i[rtcapt_pkg::STAT_EVT];
    nxt_tamp = tamper_input_n_i;
    cap = ctrl_ff[rtcapt_pkg::CTL_STAMP_EN] & ~evt_ff &
      ((tamp_ff & ~tamper_input_n_i) | sw_req);
    nxt_evt = evt_ff;
    if (wr && paddr_i == rtcapt_pkg::OFF_STAT && !pwdata_i[rtcapt_pkg::STAT_EVT])
      nxt_evt = 1'b0;
    if (cap) nxt_evt = 1'b1; // Set wins over clear
    nxt_ts = ts_ff;
    if (wr && paddr_i == rtcapt_pkg::OFF_TSTL) nxt_ts.time_l = pwdata_i[15:0] & rtcapt_pkg::TIMEL_MASK;
    if (wr && paddr_i == rtcapt_pkg::OFF_TSTH) nxt_ts.time_h = pwdata_i[15:0] & rtcapt_pkg::TIMEH_MASK;
    if (wr && paddr_i == rtcapt_pkg::OFF_TSDL) nxt_ts.date_l = pwdata_i[15:0] & rtcapt_pkg::DATEL_MASK;
    if (wr && paddr_i == rtcapt_pkg::OFF_TSDH) nxt_ts.date_h = pwdata_i[15:0] & rtcapt_pkg::DATEH_MASK;
    if (cap) begin
      nxt_ts.time_l = cal_i.time_l & rtcapt_pkg::TIMEL_MASK;
      nxt_ts.time_h = cal_i.time_h & rtcapt_pkg::TIMEH_MASK;
      nxt_ts.date_l = cal_i.date_l & rtcapt_pkg::DATEL_MASK;
      nxt_ts.date_h = cal_i.date_h & rtcapt_pkg::DATEH_MASK;
    end
  end
  assign stamp_irq_o = cap;

  // Stamp storage: cleared only by power-on reset
  always_ff @(posedge mclk_i or negedge por_n_i) begin
    if (!por_n_i) ts_ff <= '0;
    else ts_ff <= nxt_ts;
  end

  // State registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= rtcapt_pkg::CTRL_RST;
      presc_ff <= rtcapt_pkg::PRESC_RST;
      pwc_ff <= rtcapt_pkg::PWC_RST;
      alt_ff <= 32'h0000_0000;
      ald_ff <= 32'h0000_0000;
      evt_ff <= 1'b0;
      pcnt_ff <= 21'h00_0000;
      tamp_ff <= 1'b1;
      pdiv_ff <= 8'h00;
      wcnt_ff <= 8'h00;
      pw_ff <= rtcapt_pkg::PW_IDLE;
    end else begin
      ctrl_ff <= nxt_ctrl;
      presc_ff <= nxt_presc;
      pwc_ff <= nxt_pwc;
      alt_ff <= nxt_alt;
      ald_ff <= nxt_ald;
      evt_ff <= nxt_evt;
      pcnt_ff <= nxt_pcnt;
      tamp_ff <= nxt_tamp;
      pdiv_ff <= nxt_pdiv;
      wcnt_ff <= nxt_wcnt;
      pw_ff <= nxt_pw;
    end
  end

  //----------------------------------------
  // Assertions
  //----------------------------------------
  AST_DISABLE_LAST: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    alm_fire && ctrl_ff[23:16] == 8'h00 && !ctrl_ff[3] |=> !ctrl_ff[2])
    else $error("alarm not disabled after last");
  AST_DECR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    alm_fire && ctrl_ff[23:16] != 8'h00 && !wr |=> ctrl_ff[23:16] == $past(ctrl_ff[23:16]) - 8'h01)
    else $error("repeat count not decremented");
  AST_WRAP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    alm_fire && ctrl_ff[23:16] == 8'h00 && ctrl_ff[3] && !wr |=> ctrl_ff[23:16] == 8'hFF && ctrl_ff[2])
    else $error("endless repeat did not wrap");
  AST_BLOCK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    evt_ff |-> !cap)
    else $error("capture while flag set");
  AST_FLAG: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cap |=> evt_ff && ts_ff.date_l == ($past(cal_i.date_l) & 16'h3F07))
    else $error("capture did not flag");
  AST_GATE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sample_gate_o |-> pw_on)
    else $error("sample gate without power");
  AST_POL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    power_control_o == (pw_on == ctrl_ff[5]))
    else $error("power polarity wrong");
  AST_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pwc_ff[7:0] == 8'hFF && ctrl_ff[5] |-> power_control_o)
    else $error("stability hold lost");
  COV_ALARM: cover property (@(posedge mclk_i) alm_fire);
  COV_CAP: cover property (@(posedge mclk_i) cap);
  COV_SAMP: cover property (@(posedge mclk_i) sample_gate_o);
endmodule // rtcapt_top

// [rtcapt_far.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Far side: tamper source, half-second strobe
// ----------------------------------------
module rtcapt_far #(parameter int HS = 7) (
  input wire logic mclk_i,        // Clock
  input wire logic trig_i,        // Request one tamper pulse
  output logic tamper_input_n_o,  // Tamper line, low active
  output logic half_sec_o         // Half-second strobe
);
  int hs_cnt = 0;
  int low_cnt = 0;
  initial tamper_input_n_o = 1'b1;
  initial half_sec_o = 1'b0;
  // Three-cycle low pulse per request, strobe every HS cycles
  always @(posedge mclk_i) begin
    if (trig_i) low_cnt <= 3;
    else if (low_cnt > 0) low_cnt <= low_cnt - 1;
    tamper_input_n_o <= !(low_cnt > 0);
    hs_cnt <= (hs_cnt == HS - 1) ? 0 : hs_cnt + 1;
    half_sec_o <= (hs_cnt == 0);
  end
endmodule // rtcapt_far

// [tb_rtcapt_top.sv]
`timescale 1ns/1ps
module tb_rtcapt_top;
  localparam rtcapt_pkg::rtcapt_cal_t CAL_A = 64'h1234_5600_2507_1803;
  localparam rtcapt_pkg::rtcapt_cal_t CAL_B = 64'h0931_4200_3012_2906;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic por_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  rtcapt_pkg::rtcapt_cal_t cal_i = CAL_A;
  logic trig = 1'b0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, er, half_sec, tamper_n;
  logic sec_tick_o, alarm_irq_o, stamp_irq_o, pin_o, pin_oe_o, power_control_o, sample_gate_o;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int stamp_n = 0;
  int n, s, g;
  int f [3] = '{1, 16, 64};
  logic [31:0] dv [3] = '{32'h9, 32'hA, 32'h20};
  logic [31:0] xr [2] = '{32'h100, 32'h1_0000};

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  rtcapt_far #(.HS(7)) far_u (.mclk_i(mclk_i), .trig_i(trig),
    .tamper_input_n_o(tamper_n), .half_sec_o(half_sec));

  rtcapt_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .half_sec_i(half_sec),
    .cal_i(cal_i), .tamper_input_n_i(tamper_n), .sec_tick_o(sec_tick_o),
    .alarm_irq_o(alarm_irq_o), .stamp_irq_o(stamp_irq_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .power_control_o(power_control_o), .sample_gate_o(sample_gate_o));

  // ------------------------------
  // Bus cycles and compares
  // ------------------------------
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, v);
      error_cnt++;
    end
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    acc(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task stamp_chk(input rtcapt_pkg::rtcapt_cal_t c);
    rdchk(rtcapt_pkg::OFF_TSTL, {16'h0, c.time_l & rtcapt_pkg::TIMEL_MASK}, "stamp time low");
    rdchk(rtcapt_pkg::OFF_TSTH, {16'h0, c.time_h & rtcapt_pkg::TIMEH_MASK}, "stamp time high");
    rdchk(rtcapt_pkg::OFF_TSDL, {16'h0, c.date_l & rtcapt_pkg::DATEL_MASK}, "stamp date low");
    rdchk(rtcapt_pkg::OFF_TSDH, {16'h0, c.date_h & rtcapt_pkg::DATEH_MASK}, "stamp date high");
  endtask

  // Cycles between two ticks
  task per(output int c);
    c = 0;
    do @(posedge mclk_i); while (sec_tick_o !== 1'b1);
    do begin
      @(posedge mclk_i);
      c++;
    end while (sec_tick_o !== 1'b1);
  endtask

  task cnt_al(input int c, output int k);
    k = 0;
    repeat (c) begin
      @(posedge mclk_i);
      if (alarm_irq_o === 1'b1) k++;
    end
  endtask

  task pulse_tamper();
    trig <= 1'b1;
    @(posedge mclk_i);
    trig <= 1'b0;
    repeat (10) @(posedge mclk_i);
  endtask

  task results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Stamp pulse count and hang guard
  always @(posedge mclk_i) begin
    if (stamp_irq_o === 1'b1) stamp_n++;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    rdchk(rtcapt_pkg::OFF_CTRL, rtcapt_pkg::CTRL_RST, "ctrl reset");
    rdchk(rtcapt_pkg::OFF_DIV, {11'h0, rtcapt_pkg::PRESC_RST}, "prescaler reset");
    rdchk(rtcapt_pkg::OFF_PWC, 32'h0, "window reset");
    chk("power idle", 32'h1, {31'h0, power_control_o});
    acc(1'b0, 12'h0FC, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    // Storage use, unused bits read zero
    acc(1'b1, rtcapt_pkg::OFF_TSDL, 32'hFFFF_FFFF);
    rdchk(rtcapt_pkg::OFF_TSDL, 32'h3F07, "date low bits");
    acc(1'b1, rtcapt_pkg::OFF_TSDH, 32'hFFFF_FFFF);
    rdchk(rtcapt_pkg::OFF_TSDH, 32'hFF1F, "date high bits");
    // Tick period follows joined divider
    acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, rtcapt_pkg::OFF_DIV, dv[i]);
      per(n);
      chk("tick period", dv[i] + 1, n);
    end
    acc(1'b1, rtcapt_pkg::OFF_DIV, 32'h9);
    // One-shot and counted repeats
    for (int r = 0; r < 3; r += 2) begin
      acc(1'b1, rtcapt_pkg::OFF_CTRL, {8'h0, 8'(r), 16'h0105});
      cnt_al(150, n);
      chk("alarm count", r + 1, n);
      rdchk(rtcapt_pkg::OFF_CTRL, {8'h0, 8'h0, 16'h0101}, "auto disable");
    end
    acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h0000_010D);
    cnt_al(100, n);
    chk("endless alarms", 32'h1, {31'h0, n >= 9});
    acc(1'b0, rtcapt_pkg::OFF_CTRL, 32'h0);
    chk("endless stays on", 32'h1, {31'h0, rd[rtcapt_pkg::CTL_ALM_EN]});
    acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h0);
    // Alarm values set while disabled
    acc(1'b1, rtcapt_pkg::OFF_ALT, {CAL_A.time_h, CAL_A.time_l});
    acc(1'b1, rtcapt_pkg::OFF_ALD, {CAL_A.date_h, CAL_A.date_l});
    for (int m = 0; m < 10; m++) begin
      acc(1'b1, rtcapt_pkg::OFF_CTRL, {20'h0, 4'(m), 8'h0D});
      cnt_al(40, n);
      chk("mask fires", 32'h1, {31'h0, n > 0});
      acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h0);
    end
    // Seconds digit compared, minutes ignored, for mask 2
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, rtcapt_pkg::OFF_ALT, {CAL_A.time_h, CAL_A.time_l} ^ xr[i]);
      acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h0000_020D);
      cnt_al(40, n);
      chk("digit compare", i, {31'h0, n > 0});
      acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h0);
    end
    // Power cycles under prescales 0 to 2
    acc(1'b1, rtcapt_pkg::OFF_DIV, 32'd999);
    acc(1'b1, rtcapt_pkg::OFF_PWC, 32'h0302);
    for (int p = 0; p < 3; p++) begin
      acc(1'b1, rtcapt_pkg::OFF_CTRL, {2'b00, 2'(p), 1'b0, 3'h3, 16'h0001, 8'h7D});
      do @(posedge mclk_i); while (power_control_o !== 1'b1);
      s = 0;
      g = 0;
      while (sample_gate_o !== 1'b1) begin
        @(posedge mclk_i);
        s++;
      end
      chk("pin level", 32'h1, {31'h0, pin_o});
      while (sample_gate_o === 1'b1) begin
        @(posedge mclk_i);
        g++;
      end
      chk("stability window", 2 * f[p], s);
      chk("sample window", 3 * f[p], g);
      chk("power off", 32'h0, {31'h0, power_control_o});
      chk("pin enable", 32'h1, {31'h0, pin_oe_o});
      acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h0);
    end
    // Stability field FFh holds power on with power control off
    acc(1'b1, rtcapt_pkg::OFF_PWC, 32'h00FF);
    @(posedge mclk_i);
    chk("stability hold", 32'h0, {31'h0, power_control_o});
    acc(1'b1, rtcapt_pkg::OFF_PWC, 32'h0);
    // Hardware capture, blocking, software capture
    acc(1'b1, rtcapt_pkg::OFF_CTRL, 32'h3);
    pulse_tamper();
    stamp_chk(CAL_A);
    acc(1'b0, rtcapt_pkg::OFF_STAT, 32'h0);
    chk("event flag", 32'h1, {31'h0, rd[rtcapt_pkg::STAT_EVT]});
    cal_i <= CAL_B;
    pulse_tamper();
    stamp_chk(CAL_A);
    acc(1'b1, rtcapt_pkg::OFF_STAT, 32'h0);
    acc(1'b1, rtcapt_pkg::OFF_STAT, 32'h8);
    repeat (3) @(posedge mclk_i);
    acc(1'b0, rtcapt_pkg::OFF_STAT, 32'h0);
    chk("soft flag", 32'h1, {31'h0, rd[rtcapt_pkg::STAT_EVT]});
    stamp_chk(CAL_B);
    chk("stamp pulses", 32'd2, stamp_n);
    // Warm reset keeps stamps
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    stamp_chk(CAL_B);
    // Power-on reset clears stamps
    por_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    por_n_i <= 1'b1;
    rdchk(rtcapt_pkg::OFF_TSDL, 32'h0, "stamp after power-on");
    results();
  end
endmodule // tb_rtcapt_top
